/* File: inc/dia_pkg.sv */
package dia_pkg;
   // Channel count and field widths
   localparam int NUM_CH        = 2;
   localparam int SPEED_W       = 7;
   localparam int GEAR_W        = 8;
   localparam int FUSE_W        = 8;
   localparam int SEL_W         = 5;
   localparam int SHED_W        = 2;

   // Register byte offsets, channel 1 block then channel 2 block, then shared registers
   localparam logic [7:0] OFS_CH_STRIDE = 8'h20;
   localparam logic [7:0] OFS_LATCH_EN  = 8'h00;
   localparam logic [7:0] OFS_SPEED     = 8'h04;
   localparam logic [7:0] OFS_GEAR      = 8'h08;
   localparam logic [7:0] OFS_FUSE      = 8'h0c;
   localparam logic [7:0] OFS_SELECT    = 8'h10;
   localparam logic [7:0] OFS_SHED      = 8'h14;
   localparam logic [7:0] OFS_STATUS    = 8'h40;
   localparam logic [7:0] OFS_MASK      = 8'h44;
   localparam logic [7:0] OFS_OUTPUTS   = 8'h48;

   // Reset values, write limits and neutral gear
   localparam logic              RST_LATCH_EN = 1'b0;
   localparam logic [SPEED_W-1:0] RST_SPEED   = 7'h1e;
   localparam logic [SPEED_W-1:0] MAX_SPEED   = 7'h64;
   localparam logic [GEAR_W-1:0]  RST_GEAR    = 8'h7d;
   localparam logic [GEAR_W-1:0]  MAX_GEAR    = 8'hfa;
   localparam logic [GEAR_W-1:0]  GEAR_NEUTRAL = 8'h7d;
   localparam logic [FUSE_W-1:0]  RST_FUSE    = 8'hc8;
   localparam logic [SEL_W-1:0]   RST_SELECT  = 5'h0a;
   localparam logic [SEL_W-1:0]   MAX_SELECT  = 5'h10;
   localparam logic [SHED_W-1:0]  RST_SHED    = 2'h1;
   localparam logic [3:0]         RST_MASK    = 4'h0;

   // Status bit positions per channel: interlock trip, fuse trip
   localparam int ST_ILOCK = 0;
   localparam int ST_FUSE  = 1;

   // Key states
   typedef enum logic [1:0] {
      DIA_KEY_OFF, DIA_KEY_ACC, DIA_KEY_RUN, DIA_KEY_CRANK
   } dia_key_e;

   // Vehicle condition inputs
   typedef struct packed {
      logic                park_brake;
      logic                door_open;
      logic                power_takeoff;
      logic                engine_running;
      logic                moving;
      logic [SPEED_W-1:0]  speed_mph;
      logic [GEAR_W-1:0]   gear;
   } dia_veh_s;

   // Per-channel configuration
   typedef struct packed {
      logic                latch_en;
      logic [SPEED_W-1:0]  speed_thr;
      logic [GEAR_W-1:0]   gear_thr;
      logic [FUSE_W-1:0]   fuse_limit;
      logic [SEL_W-1:0]    cond_sel;
      logic [SHED_W-1:0]   shed_pri;
   } dia_cfg_s;

   typedef enum logic [1:0] {DIA_OFF, DIA_ON, DIA_TRIPPED} dia_ch_e;
endpackage : dia_pkg

/* File: design/dia_aux_output.sv */
`timescale 1ns/100ps
module dia_aux_output (
   input  wire logic                                  clk_sys,
   input  wire logic                                  reset,
   input  wire logic [dia_pkg::NUM_CH-1:0]            switch_in,
   input  wire logic [1:0]                            key_run_state,
   input  wire dia_pkg::dia_veh_s                     veh_in,
   input  wire logic [dia_pkg::NUM_CH*dia_pkg::FUSE_W-1:0] load_current,
   input  wire logic [1:0]                            shed_level,
   input  wire logic [7:0]                            avs_address,
   input  wire logic                                  avs_read,
   input  wire logic                                  avs_write,
   input  wire logic [31:0]                           avs_writedata,
   output logic [31:0]                                avs_readdata,
   output logic                                       avs_waitrequest,
   output logic [dia_pkg::NUM_CH-1:0]                 aux_out,
   output logic                                       irq
);
   import dia_pkg::*;

   typedef struct packed {
      logic [2:0][NUM_CH-1:0] sw_sync;
      dia_veh_s [2:0]         veh_sync;
      logic [2:0][1:0]        key_sync;
      dia_veh_s               veh_prev;
      logic [1:0]             key_prev;
      logic [NUM_CH-1:0]      sw_prev;
      logic [NUM_CH-1:0]      latched;
      logic [NUM_CH-1:0]      fuse_trip;
      logic [NUM_CH-1:0]      out;
      dia_cfg_s [NUM_CH-1:0]  cfg;
      logic [3:0]             status;
      logic [3:0]             mask;
      logic                   ack;
      logic [31:0]            rdata;
   } dia_state_s;

   dia_state_s st_ff;
   dia_state_s nxt_st;

   ////////////////////////////////////////////////////////////////////////
   // Interlock condition evaluation for one channel
   function automatic logic dia_cond_ok(input dia_cfg_s c,
                                        input dia_veh_s v);
      logic ok;
      ok = 1'b0;
      case (c.cond_sel)
         5'h00: ok = 1'b1;
         5'h01: ok = v.park_brake;
         5'h02: ok = !v.park_brake;
         5'h03: ok = v.door_open;
         5'h04: ok = !v.door_open;
         5'h05: ok = v.power_takeoff;
         5'h06: ok = !v.power_takeoff;
         5'h07: ok = v.engine_running;
         5'h08: ok = !v.engine_running;
         5'h09: ok = v.speed_mph > c.speed_thr;
         5'h0a: ok = v.speed_mph < c.speed_thr;
         5'h0b: ok = !v.moving;
         5'h0c: ok = v.moving;
         5'h0d: ok = v.gear > c.gear_thr;
         5'h0e: ok = v.gear < c.gear_thr;
         5'h0f: ok = v.gear == GEAR_NEUTRAL;
         5'h10: ok = v.gear != GEAR_NEUTRAL;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction : dia_cond_ok

   // Register offset within a channel block, and channel index
   function automatic logic [7:0] dia_local(input logic [7:0] a);
      return (a >= OFS_CH_STRIDE && a < OFS_STATUS) ?
             8'(a - OFS_CH_STRIDE) : a;
   endfunction : dia_local

   function automatic logic dia_chan(input logic [7:0] a);
      return (a >= OFS_CH_STRIDE && a < OFS_STATUS);
   endfunction : dia_chan

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      logic [NUM_CH-1:0] sw;
      logic [NUM_CH-1:0] ev_ilock;
      logic [NUM_CH-1:0] ev_fuse;
      logic              key_ok;
      dia_veh_s          veh;
      logic [1:0]        key;
      logic              cond;
      logic              shed;
      logic [FUSE_W-1:0] amps;
      logic [7:0]        loc;
      logic              ch;
      sw       = '0;
      ev_ilock = '0;
      ev_fuse  = '0;
      key_ok   = 1'b0;
      veh      = '0;
      key      = '0;
      cond     = 1'b0;
      shed     = 1'b0;
      amps     = '0;
      loc      = dia_local(avs_address);
      ch       = dia_chan(avs_address);
      nxt_st   = st_ff;

      // Input synchronisers; a change counts once stages 2 and 3 agree
      nxt_st.sw_sync  = {st_ff.sw_sync[1:0], switch_in};
      nxt_st.veh_sync = {st_ff.veh_sync[1:0], veh_in};
      nxt_st.key_sync = {st_ff.key_sync[1:0], key_run_state};
      for (int i = 0; i < NUM_CH; i++) begin
         sw[i] = (st_ff.sw_sync[1][i] == st_ff.sw_sync[2][i]) ?
                 st_ff.sw_sync[2][i] : st_ff.sw_prev[i];
      end
      // Multi-bit words pass only when two stages agree, else hold
      veh = (st_ff.veh_sync[1] == st_ff.veh_sync[2]) ?
            st_ff.veh_sync[2] : st_ff.veh_prev;
      key = (st_ff.key_sync[1] == st_ff.key_sync[2]) ?
            st_ff.key_sync[2] : st_ff.key_prev;
      key_ok = (key == DIA_KEY_RUN || key == DIA_KEY_ACC);
      nxt_st.sw_prev  = sw;
      nxt_st.veh_prev = veh;
      nxt_st.key_prev = key;

      // Channel logic, each channel self-contained
      for (int i = 0; i < NUM_CH; i++) begin
         cond = dia_cond_ok(st_ff.cfg[i], veh);
         amps = load_current[i*FUSE_W +: FUSE_W];
         // Level 0 never sheds; higher system level sheds more
         shed = (st_ff.cfg[i].shed_pri != 2'h0) &&
                (shed_level >= st_ff.cfg[i].shed_pri);
         if (!sw[i]) begin
            nxt_st.latched[i]   = 1'b0;
            nxt_st.fuse_trip[i] = 1'b0;
         end else begin
            if (st_ff.out[i] && !cond && st_ff.cfg[i].latch_en) begin
               nxt_st.latched[i] = 1'b1;
            end
            if (st_ff.out[i] && !cond) begin
               ev_ilock[i] = 1'b1;
            end
            if (st_ff.out[i] && amps > st_ff.cfg[i].fuse_limit) begin
               nxt_st.fuse_trip[i] = 1'b1;
               ev_fuse[i] = 1'b1;
            end
         end
         // After an interlock trip, re-arms on its own when latch-off is disabled; a fuse trip holds until the switch goes off
         nxt_st.out[i] = sw[i] && key_ok && cond &&
                         !nxt_st.latched[i] && !nxt_st.fuse_trip[i] &&
                         !shed;
      end

      // Avalon slave: one wait cycle; a write lands with waitrequest low
      nxt_st.ack = (avs_read || avs_write) && !st_ff.ack;
      if (avs_write && st_ff.ack) begin
         case (loc)
            OFS_LATCH_EN: nxt_st.cfg[ch].latch_en = avs_writedata[0];
            OFS_SPEED: begin
               if (avs_writedata <= 32'(MAX_SPEED)) begin
                  nxt_st.cfg[ch].speed_thr = avs_writedata[6:0];
               end
            end
            OFS_GEAR: begin
               if (avs_writedata <= 32'(MAX_GEAR)) begin
                  nxt_st.cfg[ch].gear_thr = avs_writedata[7:0];
               end
            end
            OFS_FUSE: begin
               if (avs_writedata <= 32'(RST_FUSE)) begin
                  nxt_st.cfg[ch].fuse_limit = avs_writedata[7:0];
               end
            end
            OFS_SELECT: begin
               if (avs_writedata <= 32'(MAX_SELECT)) begin
                  nxt_st.cfg[ch].cond_sel = avs_writedata[4:0];
               end
            end
            OFS_SHED: begin
               if (avs_writedata[31:SHED_W] == '0) begin
                  nxt_st.cfg[ch].shed_pri = avs_writedata[1:0];
               end
            end
            OFS_MASK: nxt_st.mask = avs_writedata[3:0];
            default: ;
         endcase
      end
      nxt_st.rdata = '0;
      if (avs_read && !st_ff.ack) begin
         case (loc)
            OFS_LATCH_EN: nxt_st.rdata = {31'h0, st_ff.cfg[ch].latch_en};
            OFS_SPEED:    nxt_st.rdata = {25'h0, st_ff.cfg[ch].speed_thr};
            OFS_GEAR:     nxt_st.rdata = {24'h0, st_ff.cfg[ch].gear_thr};
            OFS_FUSE:     nxt_st.rdata = {24'h0, st_ff.cfg[ch].fuse_limit};
            OFS_SELECT:   nxt_st.rdata = {27'h0, st_ff.cfg[ch].cond_sel};
            OFS_SHED:     nxt_st.rdata = {30'h0, st_ff.cfg[ch].shed_pri};
            OFS_STATUS:   nxt_st.rdata = {28'h0, st_ff.status};
            OFS_MASK:     nxt_st.rdata = {28'h0, st_ff.mask};
            OFS_OUTPUTS:  nxt_st.rdata = {30'h0, st_ff.out};
            default:      nxt_st.rdata = 32'h0;
         endcase
         if (loc == OFS_STATUS) begin
            nxt_st.status = '0;
         end
      end

      // Sticky events; a new event wins over the read clear
      for (int i = 0; i < NUM_CH; i++) begin
         if (ev_ilock[i]) begin
            nxt_st.status[2*i+ST_ILOCK] = 1'b1;
         end
         if (ev_fuse[i]) begin
            nxt_st.status[2*i+ST_FUSE] = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         st_ff <= '0;
         for (int i = 0; i < NUM_CH; i++) begin
            st_ff.cfg[i].latch_en   <= RST_LATCH_EN;
            st_ff.cfg[i].speed_thr  <= RST_SPEED;
            st_ff.cfg[i].gear_thr   <= RST_GEAR;
            st_ff.cfg[i].fuse_limit <= RST_FUSE;
            st_ff.cfg[i].cond_sel   <= RST_SELECT;
            st_ff.cfg[i].shed_pri   <= RST_SHED;
         end
         st_ff.mask <= RST_MASK;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs
   assign avs_waitrequest = (avs_read || avs_write) && !st_ff.ack;
   assign avs_readdata    = st_ff.rdata;
   assign aux_out         = st_ff.out;
   assign irq             = |(st_ff.status & st_ff.mask);
endmodule : dia_aux_output

/* File: tb/dia_props.sv */
`timescale 1ns/100ps
// Port-level properties of the dual interlocked output block
module dia_props
   import dia_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        reset,
   input wire logic [1:0]  switch_in,
   input wire logic [1:0]  key_run_state,
   input wire logic [15:0] load_current,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic        avs_waitrequest,
   input wire logic [1:0]  aux_out,
   input wire logic        irq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   ////////////////////////////////////////////////////////////////////////
   // Key and switch gating, four cycles through the synchronisers; fuse gating on the unsynchronised current
   a_key_off_gate: assert property ((key_run_state == 2'h0)[*5] |->
      aux_out == 2'h0) else $error("output on with key off");
   a_key_rise_ok: assert property ($rose(aux_out[0]) |->
      $past(key_run_state, 4) inside {2'h1, 2'h2})
      else $error("output rose without key run");
   a_sw_off_ch1: assert property ((!switch_in[0])[*5] |->
      !aux_out[0]) else $error("ch1 on with switch off");
   a_sw_off_ch2: assert property ((!switch_in[1])[*5] |->
      !aux_out[1]) else $error("ch2 on with switch off");
   a_sw_rise_ch2: assert property ($rose(aux_out[1]) |->
      $past(switch_in[1], 4)) else $error("ch2 rose without switch");
   a_fuse_ch1_off: assert property ((load_current[7:0] > 8'hc8)[*3]
      |-> !aux_out[0]) else $error("ch1 on above fuse limit");
   a_fuse_ch2_off: assert property ((load_current[15:8] > 8'hc8)[*3]
      |-> !aux_out[1]) else $error("ch2 on above fuse limit");

   ////////////////////////////////////////////////////////////////////////
   // Bus answers after exactly one wait cycle
   a_wait_first: assert property ($rose(avs_read | avs_write) |->
      avs_waitrequest) else $error("no wait cycle");
   a_wait_one: assert property ((avs_read | avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("wait longer than one cycle");

   // Main scenarios reached
   c_both_on: cover property (aux_out == 2'h3);
   c_irq: cover property (irq);
   c_read_ack: cover property (avs_read && !avs_waitrequest);
endmodule : dia_props

/* File: tb/dia_partner.sv */
`timescale 1ns/100ps
// Operator rockers and remote output module current sense
module dia_partner (
   input  wire logic        clk_sys,
   input  wire logic [1:0]  sw_req,
   input  wire logic [15:0] amps_req,
   output logic [1:0]       switch_in = 2'h0,
   output logic [15:0]      load_current = 16'h0
);
   // Latched rocker holds position; current reported once per cycle
   always_ff @(posedge clk_sys) begin
      switch_in    <= sw_req;
      load_current <= amps_req;
   end
endmodule : dia_partner

/* File: tb/dia_aux_output_test.sv */
`timescale 1ns/100ps
module dia_aux_output_test;
   import dia_pkg::*;
   logic        clk_sys = 1'b0;
   logic        reset = 1'b1;
   logic [1:0]  sw_req = 2'h0;
   logic [15:0] amps_req = 16'h0;
   logic [1:0]  switch_in;
   logic [1:0]  key_run_state = 2'h0;
   dia_veh_s    veh_in = '0;
   dia_veh_s    va = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 7'h32, 8'h82};
   dia_veh_s    vb = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 7'h00, 8'h7d};
   logic [15:0] load_current;
   logic [1:0]  shed_level = 2'h0;
   logic [7:0]  avs_address = 8'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [1:0]  aux_out;
   logic        irq;
   logic [31:0] rdv;
   int          num_errors = 0;
   int          checks_done = 0;

   // Clock and instances
   always #5 clk_sys = ~clk_sys;
   dia_aux_output uut (.clk_sys, .reset, .switch_in, .key_run_state,
      .veh_in, .load_current, .shed_level, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
      .aux_out, .irq);
   dia_partner far (.clk_sys, .sw_req, .amps_req, .switch_in,
      .load_current);

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check

   // One Avalon access, held until waitrequest is sampled low at a rise
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk_sys);
      avs_address   <= a;
      avs_read      <= ~w;
      avs_write     <= w;
      avs_writedata <= d;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      rdv = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic settle;
      repeat (8) @(posedge clk_sys);
   endtask : settle

   ////////////////////////////////////////////////////////////////////////
   task automatic t_defaults;
      logic [31:0] e[6] = '{32'h0, 32'h1e, 32'h7d, 32'hc8, 32'ha, 32'h1};
      for (int c = 0; c < 2; c++)
         for (int i = 0; i < 6; i++) begin
            bus(1'b0, 8'(c * 32 + i * 4), 32'h0);
            check(rdv, e[i]);
         end
      bus(1'b0, 8'h38, 32'h0);
      check(rdv, 32'h0);
      bus(1'b1, OFS_SPEED, 32'h65);
      bus(1'b0, OFS_SPEED, 32'h0);
      check(rdv, 32'h1e);
      bus(1'b1, OFS_SELECT, 32'h11);
      bus(1'b0, OFS_SELECT, 32'h0);
      check(rdv, 32'ha);
      bus(1'b1, OFS_SHED, 32'h5);
      bus(1'b0, OFS_SHED, 32'h0);
      check(rdv, 32'h1);
      bus(1'b1, OFS_SPEED, 32'h90);
      bus(1'b0, OFS_SPEED, 32'h0);
      check(rdv, 32'h1e);
   endtask : t_defaults

   task automatic t_key;
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_sys) key_run_state <= 2'(k);
         settle;
         check(aux_out, (k == 1 || k == 2) ? 2'h3 : 2'h0);
      end
      @(posedge clk_sys) begin
         key_run_state <= 2'h2;
         sw_req        <= 2'h1;
      end
      settle;
      check(aux_out, 2'h1);
      bus(1'b0, OFS_OUTPUTS, 32'h0);
      check(rdv, 32'h1);
      @(posedge clk_sys) sw_req <= 2'h3;
   endtask : t_key

   task automatic t_speed;
      bus(1'b1, OFS_MASK, 32'h1);
      bus(1'b1, OFS_SPEED, 32'h64);
      bus(1'b0, OFS_SPEED, 32'h0);
      check(rdv, 32'h64);
      bus(1'b1, OFS_SPEED, 32'h1e);
      @(posedge clk_sys) veh_in.speed_mph <= 7'h1e;
      settle;
      check(aux_out, 2'h0);
      check(irq, 1'b1);
      @(posedge clk_sys) veh_in.speed_mph <= 7'h1d;
      settle;
      check(aux_out, 2'h3);
      bus(1'b0, OFS_STATUS, 32'h0);
      check(rdv[3:0], 4'h5);
      settle;
      check(irq, 1'b0);
      bus(1'b1, OFS_MASK, 32'h0);
   endtask : t_speed

   task automatic t_latch;
      bus(1'b1, OFS_LATCH_EN, 32'h1);
      @(posedge clk_sys) veh_in.speed_mph <= 7'h1e;
      settle;
      veh_in.speed_mph <= 7'h1d;
      settle;
      check(aux_out, 2'h2);
      sw_req <= 2'h2;
      settle;
      sw_req <= 2'h3;
      settle;
      check(aux_out, 2'h3);
      bus(1'b1, OFS_LATCH_EN, 32'h0);
      bus(1'b0, OFS_STATUS, 32'h0);
   endtask : t_latch

   task automatic t_fuse;
      @(posedge clk_sys) amps_req <= 16'h00c8;
      settle;
      check(aux_out, 2'h3);
      amps_req <= 16'h00c9;
      settle;
      check(aux_out, 2'h2);
      bus(1'b0, OFS_STATUS, 32'h0);
      check(rdv[3:0], 4'h2);
      amps_req <= 16'h0;
      sw_req <= 2'h2;
      settle;
      sw_req <= 2'h3;
      settle;
      check(aux_out, 2'h3);
   endtask : t_fuse

   task automatic t_shed;
      @(posedge clk_sys) shed_level <= 2'h1;
      settle;
      check(aux_out, 2'h0);
      bus(1'b1, OFS_CH_STRIDE + OFS_SHED, 32'h0);
      bus(1'b1, OFS_SHED, 32'h3);
      shed_level <= 2'h2;
      settle;
      check(aux_out, 2'h3);
      shed_level <= 2'h3;
      settle;
      check(aux_out, 2'h2);
      shed_level <= 2'h0;
   endtask : t_shed

   // Each selector against two opposite vehicle states
   task automatic t_select;
      logic [16:0] on_a = 17'h132ab;
      logic [16:0] on_b = 17'h08d55;
      for (int s = 0; s < 17; s++) begin
         bus(1'b1, OFS_SELECT, 32'(s));
         veh_in <= va;
         settle;
         check(aux_out[0], on_a[s]);
         veh_in <= vb;
         settle;
         check(aux_out[0], on_b[s]);
      end
   endtask : t_select

   // Mid-run reset: outputs drop at once, settings return to defaults
   task automatic t_reset;
      @(posedge clk_sys) reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      check(aux_out, 2'h0);
      check(irq, 1'b0);
      reset <= 1'b0;
      bus(1'b0, OFS_SELECT, 32'h0);
      check(rdv, 32'ha);
      settle;
      check(aux_out, 2'h3);
   endtask : t_reset

   ////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done

   // Main sequence
   initial begin
      repeat (20) @(posedge clk_sys);
      reset <= 1'b0;
      key_run_state <= 2'h2;
      sw_req <= 2'h3;
      t_defaults;
      t_key;
      t_speed;
      t_latch;
      t_fuse;
      t_shed;
      t_select;
      t_reset;
      test_done;
   end

   // Watchdog
   initial begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      test_done;
   end
endmodule : dia_aux_output_test

bind dia_aux_output dia_props chk (.clk_sys, .reset, .switch_in,
   .key_run_state, .load_current, .avs_read, .avs_write,
   .avs_waitrequest, .aux_out, .irq);
